// File: cvm_channel.sv
`timescale 1ns/1ps
`default_nettype none
module cvm_channel
  import cvm_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic                    frame_tick,
  input  wire logic [CVM_SAMPLE_W-1:0] sample,
  input  wire logic [CVM_LEVEL_W-1:0]  target_level,
  input  wire logic                    mute_req,
  input  wire logic                    soft_en,
  input  wire logic [1:0]              step_dwell_sel,
  input  wire logic                    zero_run_silence_en,
  output logic [CVM_LEVEL_W-1:0]       level_ff,
  output logic                         pending_ff,
  output logic                         zero_mute_ff
);
  // ==========================================================================
  // Goal, zero detection and runs
  // ==========================================================================
  logic [CVM_LEVEL_W-1:0]  goal;
  logic [CVM_LEVEL_W-1:0]  goal_prev_ff;
  logic                    sign_prev_ff;
  logic                    zc;
  logic [CVM_CNT_W-1:0]    zrun_ff;
  logic [CVM_CNT_W-1:0]    tmo_ff;
  logic [CVM_DWELL_W-1:0]  dwell_ff;
  logic                    zero_smp;

  assign zero_smp = (sample == '0) || (sample == '1);
  assign goal = (mute_req || zero_mute_ff) ? CVM_LEVEL_MUTE : target_level;
  assign zc = frame_tick && (sample[CVM_SAMPLE_W-1] != sign_prev_ff || sample == '0);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sign_prev_ff <= 1'b0;
    end else if (frame_tick) begin
      sign_prev_ff <= sample[CVM_SAMPLE_W-1];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      zrun_ff      <= '0;
      zero_mute_ff <= 1'b0;
    end else if (!zero_run_silence_en) begin
      zrun_ff      <= '0;
      zero_mute_ff <= 1'b0;
    end else if (frame_tick) begin
      if (!zero_smp) begin
        zrun_ff      <= '0;
        zero_mute_ff <= 1'b0;
      end else if (zrun_ff == CVM_ZERO_RUN_FR) begin
        zero_mute_ff <= 1'b1;
      end else begin
        zrun_ff <= zrun_ff + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Level stepping
  // ==========================================================================
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      level_ff     <= '0;
      dwell_ff     <= '0;
      tmo_ff       <= '0;
      goal_prev_ff <= '0;
      pending_ff   <= 1'b0;
    end else begin
      goal_prev_ff <= goal;
      if (goal != goal_prev_ff) begin
        pending_ff <= 1'b1;
        tmo_ff     <= '0;
      end else if (level_ff == goal) begin
        pending_ff <= 1'b0;
      end
      if (frame_tick && level_ff != goal) begin
        if (soft_en) begin
          // Newest goal steers each step, so a retarget never finishes the old ramp.
          if (dwell_ff + 1'b1 >= cvm_dwell(step_dwell_sel)) begin
            dwell_ff <= '0;
            level_ff <= (level_ff < goal) ? level_ff + 1'b1 : level_ff - 1'b1;
          end else begin
            dwell_ff <= dwell_ff + 1'b1;
          end
        end else if (zc || tmo_ff == CVM_TIMEOUT_FR) begin
          level_ff <= goal;
          tmo_ff   <= '0;
        end else begin
          tmo_ff <= tmo_ff + 1'b1;
        end
      end
    end
  end
endmodule // cvm_channel
`default_nettype wire

// File: cvm_core.sv
`timescale 1ns/1ps
`default_nettype none
module cvm_core
  import cvm_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic                    frame_clock,
  input  wire logic                    quiet_pin_n,
  input  wire logic                    port_mode,
  input  wire logic [CVM_LEVEL_W-1:0]  left_target,
  input  wire logic [CVM_LEVEL_W-1:0]  right_target,
  input  wire logic                    soft_en,
  input  wire logic [1:0]              step_dwell_sel,
  input  wire logic                    dac_left_silence,
  input  wire logic                    dac_right_silence,
  input  wire logic                    zero_run_silence_en,
  input  wire logic [CVM_SAMPLE_W-1:0] dac_left_in,
  input  wire logic [CVM_SAMPLE_W-1:0] dac_right_in,
  input  wire logic [CVM_SAMPLE_W-1:0] adc_left_in,
  input  wire logic [CVM_SAMPLE_W-1:0] adc_right_in,
  input  wire logic                    adc_left_silence,
  input  wire logic                    adc_right_silence,
  input  wire logic                    adc_powerdown,
  input  wire logic                    left_dc_filter_bypass,
  input  wire logic                    right_dc_filter_bypass,
  input  wire logic                    mode_byte_read,
  output logic [CVM_LEVEL_W-1:0]       left_level,
  output logic [CVM_LEVEL_W-1:0]       right_level,
  output logic                         left_level_pending,
  output logic                         right_level_pending,
  output logic                         left_zero_muted,
  output logic                         right_zero_muted,
  output logic [CVM_PEAK_W-1:0]        left_peak_code,
  output logic [CVM_PEAK_W-1:0]        right_peak_code,
  output logic [CVM_SAMPLE_W-1:0]      adc_left_out,
  output logic [CVM_SAMPLE_W-1:0]      adc_right_out,
  output logic                         adc_active
);
  // ==========================================================================
  // Pin synchronisers and frame tick
  // ==========================================================================
  logic       fr_meta_ff;
  logic       fr_sync_ff;
  logic       fr_prev_ff;
  logic       qt_meta_ff;
  logic       qt_sync_ff;
  logic       frame_tick;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fr_meta_ff <= 1'b0;
      fr_sync_ff <= 1'b0;
      fr_prev_ff <= 1'b0;
      qt_meta_ff <= 1'b1;
      qt_sync_ff <= 1'b1;
    end else begin
      fr_meta_ff <= frame_clock;
      fr_sync_ff <= fr_meta_ff;
      fr_prev_ff <= fr_sync_ff;
      qt_meta_ff <= quiet_pin_n;
      qt_sync_ff <= qt_meta_ff;
    end
  end

  // One tick per sample period, on the rising edge of the frame clock.
  assign frame_tick = fr_sync_ff && !fr_prev_ff;

  // ==========================================================================
  // Effective controls
  // ==========================================================================
  logic [CVM_LEVEL_W-1:0] eff_left_tgt;
  logic [CVM_LEVEL_W-1:0] eff_right_tgt;
  logic                   eff_soft;
  logic [1:0]             eff_dwell;
  logic                   eff_zero_en;
  logic                   eff_lmute;
  logic                   eff_rmute;
  logic                   eff_adc_pd;
  logic                   eff_lbyp;
  logic                   eff_rbyp;
  logic                   eff_lsil;
  logic                   eff_rsil;

  // Stand-alone: no volume, fixed soft ramp, zero-run mute on, filter on.
  assign eff_left_tgt  = port_mode ? left_target : '0;
  assign eff_right_tgt = port_mode ? right_target : '0;
  assign eff_soft      = port_mode ? soft_en : 1'b1;
  assign eff_dwell     = port_mode ? step_dwell_sel : CVM_DWELL_RST;
  assign eff_zero_en   = port_mode ? zero_run_silence_en : 1'b1;
  assign eff_lmute     = !qt_sync_ff || (port_mode && dac_left_silence);
  assign eff_rmute     = !qt_sync_ff || (port_mode && dac_right_silence);
  assign eff_adc_pd    = port_mode && adc_powerdown;
  assign eff_lbyp      = port_mode && left_dc_filter_bypass;
  assign eff_rbyp      = port_mode && right_dc_filter_bypass;
  assign eff_lsil      = port_mode && adc_left_silence;
  assign eff_rsil      = port_mode && adc_right_silence;

  // ==========================================================================
  // DAC channels
  // ==========================================================================
  cvm_channel u_left (
    .mclk                (mclk),
    .resetn              (resetn),
    .frame_tick          (frame_tick),
    .sample              (dac_left_in),
    .target_level        (eff_left_tgt),
    .mute_req            (eff_lmute),
    .soft_en             (eff_soft),
    .step_dwell_sel      (eff_dwell),
    .zero_run_silence_en (eff_zero_en),
    .level_ff            (left_level),
    .pending_ff          (left_level_pending),
    .zero_mute_ff        (left_zero_muted)
  );

  cvm_channel u_right (
    .mclk                (mclk),
    .resetn              (resetn),
    .frame_tick          (frame_tick),
    .sample              (dac_right_in),
    .target_level        (eff_right_tgt),
    .mute_req            (eff_rmute),
    .soft_en             (eff_soft),
    .step_dwell_sel      (eff_dwell),
    .zero_run_silence_en (eff_zero_en),
    .level_ff            (right_level),
    .pending_ff          (right_level_pending),
    .zero_mute_ff        (right_zero_muted)
  );

  // ==========================================================================
  // ADC high-pass filter
  // ==========================================================================
  // Leaky DC tracker, y = x - dc; shift 11 puts the corner near 3.7 Hz at a 48 kHz rate.
  logic signed [CVM_ACC_W-1:0]    dc_l_ff;
  logic signed [CVM_ACC_W-1:0]    dc_r_ff;
  logic signed [CVM_SAMPLE_W:0]   hp_l;
  logic signed [CVM_SAMPLE_W:0]   hp_r;
  logic [CVM_SAMPLE_W-1:0]        fl_l;
  logic [CVM_SAMPLE_W-1:0]        fl_r;

  function automatic logic [CVM_SAMPLE_W-1:0] cvm_sat(input logic signed [CVM_SAMPLE_W:0] v);
    if (v[CVM_SAMPLE_W] != v[CVM_SAMPLE_W-1]) begin
      cvm_sat = v[CVM_SAMPLE_W] ? {1'b1, {(CVM_SAMPLE_W-1){1'b0}}} : {1'b0, {(CVM_SAMPLE_W-1){1'b1}}};
    end else begin
      cvm_sat = v[CVM_SAMPLE_W-1:0];
    end
  endfunction

  assign hp_l = $signed({adc_left_in[CVM_SAMPLE_W-1], adc_left_in})
              - $signed(dc_l_ff[CVM_ACC_W-1 -: CVM_SAMPLE_W+1]);
  assign hp_r = $signed({adc_right_in[CVM_SAMPLE_W-1], adc_right_in})
              - $signed(dc_r_ff[CVM_ACC_W-1 -: CVM_SAMPLE_W+1]);
  assign fl_l = eff_lbyp ? adc_left_in : cvm_sat(hp_l);
  assign fl_r = eff_rbyp ? adc_right_in : cvm_sat(hp_r);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dc_l_ff <= '0;
      dc_r_ff <= '0;
    end else if (frame_tick && !eff_adc_pd) begin
      dc_l_ff <= dc_l_ff + (CVM_ACC_W'(hp_l) <<< (CVM_ACC_W-CVM_SAMPLE_W-1-CVM_HPF_SHIFT));
      dc_r_ff <= dc_r_ff + (CVM_ACC_W'(hp_r) <<< (CVM_ACC_W-CVM_SAMPLE_W-1-CVM_HPF_SHIFT));
    end
  end

  // ==========================================================================
  // ADC output words and power
  // ==========================================================================
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      adc_left_out  <= '0;
      adc_right_out <= '0;
      adc_active    <= 1'b0;
    end else begin
      adc_active <= !eff_adc_pd;
      if (eff_adc_pd) begin
        adc_left_out  <= '0;
        adc_right_out <= '0;
      end else if (frame_tick) begin
        adc_left_out  <= eff_lsil ? '0 : fl_l;
        adc_right_out <= eff_rsil ? '0 : fl_r;
      end
    end
  end

  // ==========================================================================
  // Sticky peak monitor
  // ==========================================================================
  logic [CVM_PEAK_W-1:0] pk_l;
  logic [CVM_PEAK_W-1:0] pk_r;

  // Measured on the raw words, before filtering or silencing.
  assign pk_l = cvm_peak(adc_left_in);
  assign pk_r = cvm_peak(adc_right_in);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      left_peak_code  <= CVM_PEAK_BELOW6;
      right_peak_code <= CVM_PEAK_BELOW6;
    end else begin
      // A new worse sample in the read cycle survives the clear.
      if (frame_tick && !eff_adc_pd && pk_l > (mode_byte_read ? CVM_PEAK_BELOW6 : left_peak_code)) begin
        left_peak_code <= pk_l;
      end else if (mode_byte_read) begin
        left_peak_code <= CVM_PEAK_BELOW6;
      end
      if (frame_tick && !eff_adc_pd && pk_r > (mode_byte_read ? CVM_PEAK_BELOW6 : right_peak_code)) begin
        right_peak_code <= pk_r;
      end else if (mode_byte_read) begin
        right_peak_code <= CVM_PEAK_BELOW6;
      end
    end
  end
endmodule // cvm_core
`default_nettype wire

// File: cvm_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==================
// Core port checker
module cvm_core_chk
  import cvm_pkg::*;
(
  input wire logic                    mclk,
  input wire logic                    resetn,
  input wire logic                    frame_clock,
  input wire logic                    quiet_pin_n,
  input wire logic                    port_mode,
  input wire logic                    soft_en,
  input wire logic [CVM_LEVEL_W-1:0]  left_target,
  input wire logic                    dac_left_silence,
  input wire logic                    zero_run_silence_en,
  input wire logic                    adc_left_silence,
  input wire logic                    adc_powerdown,
  input wire logic                    mode_byte_read,
  input wire logic [CVM_LEVEL_W-1:0]  left_level,
  input wire logic                    left_level_pending,
  input wire logic                    left_zero_muted,
  input wire logic [CVM_PEAK_W-1:0]   left_peak_code,
  input wire logic [CVM_PEAK_W-1:0]   right_peak_code,
  input wire logic [CVM_SAMPLE_W-1:0] adc_left_out,
  input wire logic                    adc_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // A read far from any frame edge cannot collide with a new peak, so it must clear.
  sequence quiet_read_s; $stable(frame_clock)[*6] ##0 mode_byte_read; endsequence
  sequence soft_move_s; $changed(left_level) ##0 (!$past(port_mode) || $past(soft_en)); endsequence
  a_level_step: assert property (soft_move_s |-> (8'(left_level - $past(left_level)) inside {8'h01, 8'hff}))
    else $error("soft level moved more than one step");
  a_level_tick: assert property ($changed(left_level) |=> $stable(left_level)[*8])
    else $error("level moved twice within one frame");
  a_pend_done: assert property ($fell(left_level_pending) && $past(port_mode) && $past(quiet_pin_n) && !$past(dac_left_silence) && !$past(left_zero_muted) |-> $past(left_level) == $past(left_target))
    else $error("pending dropped before level reached target");
  a_peak_clear: assert property (quiet_read_s |=> left_peak_code == CVM_PEAK_BELOW6 && right_peak_code == CVM_PEAK_BELOW6)
    else $error("peak codes not cleared by mode read");
  a_peak_sticky: assert property (left_peak_code < $past(left_peak_code) |-> $past(mode_byte_read))
    else $error("peak code dropped without a read");
  a_adc_silence: assert property ($changed(adc_left_out) && $past(port_mode) && $past(adc_left_silence) |-> adc_left_out == '0)
    else $error("silenced adc word not zero");
  a_adc_off: assert property (port_mode && adc_powerdown |=> !adc_active)
    else $error("adc active while powered down");
  a_alone_adc: assert property (!port_mode |=> adc_active)
    else $error("stand-alone adc not active");
  a_zero_gate: assert property ($rose(left_zero_muted) |-> ($past(zero_run_silence_en) || !$past(port_mode)))
    else $error("zero mute rose while disabled");
endmodule // cvm_core_chk
bind cvm_core cvm_core_chk cvm_core_chk_inst (.mclk, .resetn, .frame_clock, .quiet_pin_n,
  .port_mode, .soft_en, .left_target, .dac_left_silence, .zero_run_silence_en, .adc_left_silence,
  .adc_powerdown, .mode_byte_read, .left_level, .left_level_pending, .left_zero_muted,
  .left_peak_code, .right_peak_code, .adc_left_out, .adc_active);
`default_nettype wire

// File: cvm_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cvm_core_tb import cvm_pkg::*; ;
  // ==================
  // Signals
  logic                    mclk, resetn, quiet_pin_n, port_mode, soft_en, l_flip, mode_byte_read;
  logic                    dac_left_silence, dac_right_silence, zero_run_silence_en;
  logic                    adc_left_silence, adc_right_silence, adc_powerdown;
  logic                    left_dc_filter_bypass, right_dc_filter_bypass, adc_active;
  logic                    frame_clock, left_level_pending, right_level_pending;
  logic                    left_zero_muted, right_zero_muted;
  logic [1:0]              step_dwell_sel;
  logic [4:0]              frame_pos;
  logic [15:0]             frames;
  logic [CVM_LEVEL_W-1:0]  left_target, right_target, left_level, right_level;
  logic [CVM_PEAK_W-1:0]   left_peak_code, right_peak_code;
  logic [CVM_SAMPLE_W-1:0] lv, rv, av, dac_left_in, dac_right_in, adc_left_in, adc_right_in;
  logic [CVM_SAMPLE_W-1:0] adc_left_out, adc_right_out;
  typedef struct { int id; logic [31:0] e; } cvm_note_s;
  cvm_note_s               notes[$];
  event                    look;
  int                      errors, check_count, meas, t0;
  string                   nm [11] = '{"left_level", "right_level", "left_pending",
    "right_pending", "left_zero_muted", "left_peak", "adc_left_out", "adc_active", "measure",
    "right_zero_muted", "adc_right_out"};
  cvm_core cvm_core_inst (.mclk, .resetn, .frame_clock, .quiet_pin_n, .port_mode, .left_target,
    .right_target, .soft_en, .step_dwell_sel, .dac_left_silence, .dac_right_silence,
    .zero_run_silence_en, .dac_left_in, .dac_right_in, .adc_left_in, .adc_right_in,
    .adc_left_silence, .adc_right_silence, .adc_powerdown, .left_dc_filter_bypass,
    .right_dc_filter_bypass, .mode_byte_read, .left_level, .right_level, .left_level_pending,
    .right_level_pending, .left_zero_muted, .right_zero_muted, .left_peak_code,
    .right_peak_code, .adc_left_out, .adc_right_out, .adc_active);
  cvm_src cvm_src_inst (.mclk, .resetn, .l_val(lv), .r_val(rv), .l_flip, .adc_val(av),
    .frame_clock, .frame_pos, .frames, .dac_left_in, .dac_right_in, .adc_left_in, .adc_right_in);
  // ==================
  // Notes and their checker
  function automatic logic [31:0] obs(int id);
    case (id)
      0: obs = left_level;
      1: obs = right_level;
      2: obs = left_level_pending;
      3: obs = right_level_pending;
      4: obs = left_zero_muted;
      5: obs = left_peak_code;
      6: obs = adc_left_out;
      7: obs = adc_active;
      9: obs = right_zero_muted;
      10: obs = adc_right_out;
      default: obs = meas;
    endcase
  endfunction
  task automatic note(int id, logic [31:0] e);
    notes.push_back('{id, e});
    ->look;
  endtask
  initial begin : mon
    cvm_note_s n;
    logic [31:0] a;
    forever begin
      @look;
      #1;
      while (notes.size() > 0) begin
        n = notes.pop_front();
        a = obs(n.id);
        check_count++;
        if (a !== n.e) begin
          errors++;
          $display("wrong value %s expected %0h seen %0h", nm[n.id], n.e, a);
        end
      end
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(int n); repeat (n) @(posedge mclk); endtask
  task automatic frm(int n); repeat (n) @(posedge frame_clock); @(posedge mclk); endtask
  // The wait is bounded so a stuck pending flag shows up as a wrong level, not a hang.
  task automatic settle(bit r, int lim);
    int f0;
    f0 = frames;
    cyc(5);
    for (int i = 0; i < lim && (r ? right_level_pending : left_level_pending) !== 1'b0; i++) cyc(1);
    meas = frames - f0;
  endtask
  // ==================
  // Clock, watchdog and tests
  initial begin mclk = 1'b0; forever #50 mclk = ~mclk; end
  initial begin #6000000; errors++; stop_test(); end
  initial begin
    {quiet_pin_n, port_mode, soft_en} = 3'h7;
    {resetn, l_flip, dac_left_silence, dac_right_silence, zero_run_silence_en} = '0;
    {adc_left_silence, adc_right_silence, adc_powerdown, mode_byte_read} = '0;
    {left_dc_filter_bypass, right_dc_filter_bypass, left_target, right_target} = '0;
    step_dwell_sel = 2'h1;
    {lv, rv, av} = {3{20'h01000}};
    void'($urandom(85952));
    cyc(2);
    resetn <= 1'b1;
    cyc(1);
    note(0, 0);
    note(2, 0);
    note(4, 0);
    note(5, 0);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      step_dwell_sel <= 2'(s);
      left_target <= (s % 2) ? 8'h00 : 8'h02;
      settle(0, 6000);
      note(0, (s % 2) ? 0 : 2);
      meas = int'(meas >= (8 << s) - 1 && meas <= (8 << s) + 2);
      note(8, 1);
    end
    step_dwell_sel <= 2'h0;
    left_target <= 8'h06;
    frm(10);
    left_target <= 8'h01;
    settle(0, 3000);
    note(0, 1);
    meas = int'(meas <= 8);
    note(8, 1);
    $display("test ramp done");
    soft_en <= 1'b0;
    l_flip <= 1'b1;
    lv <= 20'($urandom_range(20'h3ffff, 20'h00100));
    rv <= 20'($urandom_range(20'h3ffff, 20'h00100));
    frm(3);
    t0 = frames;
    left_target <= 8'h0a;
    right_target <= 8'h0a;
    settle(0, 300);
    note(0, 8'h0a);
    note(3, 1);
    settle(1, 30000);
    note(1, 8'h0a);
    meas = int'(frames - t0 >= 512 && frames - t0 <= 1026);
    note(8, 1);
    dac_left_silence <= 1'b1;
    settle(0, 300);
    note(0, 8'hff);
    dac_left_silence <= 1'b0;
    settle(0, 300);
    note(0, 8'h0a);
    quiet_pin_n <= 1'b0;
    settle(0, 300);
    note(0, 8'hff);
    quiet_pin_n <= 1'b1;
    settle(0, 300);
    note(0, 8'h0a);
    $display("test hard done");
    lv <= '0;
    frm(530);
    note(4, 0);
    zero_run_silence_en <= 1'b1;
    t0 = frames;
    for (int i = 0; i < 1100 && left_zero_muted !== 1'b1; i++) frm(1);
    note(4, 1);
    note(9, 0);
    meas = int'(frames - t0 >= 512 && frames - t0 <= 1026);
    note(8, 1);
    frm(2);
    note(0, 8'hff);
    lv <= 20'h00001;
    l_flip <= 1'b0;
    frm(2);
    cyc(4);
    note(4, 0);
    $display("test zero run done");
    {left_dc_filter_bypass, right_dc_filter_bypass} <= 2'h3;
    av <= 20'h7ffff;
    frm(3);
    note(5, 7);
    av <= 20'h00123;
    frm(3);
    note(5, 7);
    note(6, 20'h00123);
    note(10, 20'h00001);
    while (frame_pos !== 5'h12) cyc(1);
    mode_byte_read <= 1'b1;
    cyc(1);
    mode_byte_read <= 1'b0;
    cyc(2);
    note(5, 0);
    av <= 20'h55800;
    frm(3);
    note(5, 3);
    {adc_left_silence, adc_right_silence} <= 2'h3;
    frm(2);
    note(6, 0);
    note(10, 0);
    adc_powerdown <= 1'b1;
    cyc(2);
    note(7, 0);
    port_mode <= 1'b0;
    cyc(2);
    note(7, 1);
    cyc(2);
    $display("test adc done");
    stop_test();
  end
endmodule // cvm_core_tb
`default_nettype wire

// File: cvm_pkg.sv
`default_nettype none
package cvm_pkg;
  // ==========================================================================
  // Widths and encodings
  // ==========================================================================
  localparam int          CVM_LEVEL_W     = 8;
  localparam logic [7:0]  CVM_LEVEL_MUTE  = 8'hff;
  localparam int          CVM_SAMPLE_W    = 20;
  localparam int          CVM_CNT_W       = 10;
  localparam int          CVM_DWELL_W     = 6;
  localparam logic [1:0]  CVM_DWELL_RST   = 2'h1;
  localparam logic [5:0]  CVM_DWELL_4     = 6'h04;
  localparam logic [5:0]  CVM_DWELL_8     = 6'h08;
  localparam logic [5:0]  CVM_DWELL_16    = 6'h10;
  localparam logic [5:0]  CVM_DWELL_32    = 6'h20;
  localparam logic [9:0]  CVM_TIMEOUT_FR  = 10'h200;
  localparam logic [9:0]  CVM_ZERO_RUN_FR = 10'h200;
  localparam int          CVM_PEAK_W      = 3;
  localparam logic [2:0]  CVM_PEAK_BELOW6 = 3'h0;
  localparam logic [2:0]  CVM_PEAK_CLIP   = 3'h7;
  localparam int          CVM_HPF_SHIFT   = 11;
  localparam int          CVM_ACC_W       = 36;

  typedef enum logic [1:0] {
    CVM_IDLE = 2'b00,
    CVM_RAMP = 2'b01,
    CVM_WAIT = 2'b10
  } cvm_state_e;

  function automatic logic [5:0] cvm_dwell(input logic [1:0] sel);
    case (sel)
      2'h0:    cvm_dwell = CVM_DWELL_4;
      2'h1:    cvm_dwell = CVM_DWELL_8;
      2'h2:    cvm_dwell = CVM_DWELL_16;
      default: cvm_dwell = CVM_DWELL_32;
    endcase
  endfunction

  function automatic logic [2:0] cvm_peak(input logic [19:0] s);
    logic [18:0] m;
    m = s[19] ? ~s[18:0] : s[18:0];
    if (m >= 19'h7fff0)      cvm_peak = CVM_PEAK_CLIP;
    else if (m >= 19'h7214e) cvm_peak = 3'h6;
    else if (m >= 19'h65ac8) cvm_peak = 3'h5;
    else if (m >= 19'h5a9df) cvm_peak = 3'h4;
    else if (m >= 19'h50c33) cvm_peak = 3'h3;
    else if (m >= 19'h47fab) cvm_peak = 3'h2;
    else if (m >= 19'h4026e) cvm_peak = 3'h1;
    else                     cvm_peak = CVM_PEAK_BELOW6;
  endfunction
endpackage
`default_nettype wire

// File: cvm_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==================
// Frame and sample source; samples move on the frame fall so they are steady at the tick.
module cvm_src
  import cvm_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    resetn,
  input  wire logic [CVM_SAMPLE_W-1:0] l_val,
  input  wire logic [CVM_SAMPLE_W-1:0] r_val,
  input  wire logic                    l_flip,
  input  wire logic [CVM_SAMPLE_W-1:0] adc_val,
  output logic                         frame_clock,
  output logic [4:0]                   frame_pos,
  output logic [15:0]                  frames,
  output logic [CVM_SAMPLE_W-1:0]      dac_left_in,
  output logic [CVM_SAMPLE_W-1:0]      dac_right_in,
  output logic [CVM_SAMPLE_W-1:0]      adc_left_in,
  output logic [CVM_SAMPLE_W-1:0]      adc_right_in
);
  assign frame_clock = (frame_pos < 5'h0c);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frame_pos <= 5'h00;
      frames    <= 16'h0000;
    end else begin
      frame_pos <= (frame_pos == 5'h17) ? 5'h00 : frame_pos + 5'h01;
      frames    <= frames + ((frame_pos == 5'h17) ? 16'h0001 : 16'h0000);
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dac_left_in  <= '0;
      dac_right_in <= '0;
      adc_left_in  <= '0;
      adc_right_in <= '0;
    end else if (frame_pos == 5'h0c) begin
      dac_left_in  <= (l_flip && frames[0]) ? -l_val : l_val;
      dac_right_in <= r_val;
      adc_left_in  <= adc_val;
      adc_right_in <= adc_val >> 8;
    end
  end
endmodule // cvm_src
`default_nettype wire
